// ===== slx_instr_exec.sv
/*
  Decode and execute of the literal-add-and-return and computed call
  instructions. Assumes the core supplies the fetched word with its
  valid strobe at phase Q1, and applies this block's write strobes
  to its register file, program counter and return stack on the next
  clock edge.
*/
`timescale 1ns/1ps
module slx_instr_exec
  import slx_pkg::*;
(
  input wire logic clk_i, // 50 MHz core clock
  input wire logic srst_i, // Synchronous reset, active high
  input wire logic ext_set_en_i, // Extended instruction set enabled
  input wire logic [1:0] phase_i, // Current phase Q1..Q4
  input wire logic instr_valid_i, // Word valid for decode (at Q1)
  input wire logic [15:0] instr_i, // Fetched instruction word
  input wire logic [20:0] pc_i, // Address of current instruction
  input wire logic [15:0] stack_index_pointer_i, // Current pointer value
  input wire logic [20:0] return_stack_top_i, // Top of return stack
  input wire logic [7:0] working_register_i, // Working register
  input wire logic [7:0] prog_counter_latch_high_i, // High latch
  input wire logic [7:0] prog_counter_latch_upper_i, // Upper latch
  output logic ptr_we_o, // Write stack index pointer
  output logic [15:0] ptr_wdata_o, // New pointer value
  output logic pc_load_o, // Load program counter
  output logic [20:0] pc_wdata_o, // New program counter
  output logic push_o, // Push onto return stack
  output logic [20:0] push_data_o, // Pushed return address
  output logic flush_o, // Discard prefetched instruction
  output logic busy_o // Rest of the executing cycle and the nop cycle in progress
);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    slx_state_e st;
    logic ptr_we;
    logic [15:0] ptr_wdata;
    logic pc_load;
    logic [20:0] pc_wdata;
    logic push;
    logic [20:0] push_data;
    logic flush;
    logic busy;
    logic nop_cyc; // Executing cycle done, nop cycle running
  } slx_state_s;

  slx_state_s s_r;
  slx_state_s s_nxt;

  logic dec_ret;
  logic dec_call;
  logic at_q1;

  ////////////////////////////////////////////////////////////////////////
  // Decode

  // Only decode fresh words while no second cycle is pending
  assign at_q1 = instr_valid_i && (phase_i == SLX_Q1) && (s_r.st == SLX_IDLE);
  assign dec_ret = at_q1 && ext_set_en_i
    && (instr_i[15:OPC_HI_LSB] == ADD_IDX_OPC)
    && (instr_i[SEL_LSB +: 2] == SEL_STACK_RET);
  assign dec_call = at_q1 && ext_set_en_i
    && (instr_i == CALL_WORK_WORD);

  ////////////////////////////////////////////////////////////////////////
  // Next state; strobes are one clock wide

  always_comb begin
    s_nxt = s_r;
    s_nxt.ptr_we = 1'b0;
    s_nxt.pc_load = 1'b0;
    s_nxt.push = 1'b0;
    s_nxt.flush = 1'b0;
    unique case (s_r.st)
      SLX_IDLE: begin
        s_nxt.busy = 1'b0;
        if (dec_ret) begin
          // Pointer sum and return from stack top, both strobed in the same cycle
          s_nxt.ptr_we = 1'b1;
          s_nxt.ptr_wdata = stack_index_pointer_i
            + {10'h000, instr_i[LIT_LSB +: LIT_W]};
          s_nxt.pc_load = 1'b1;
          s_nxt.pc_wdata = return_stack_top_i;
          s_nxt.flush = 1'b1;
          s_nxt.busy = 1'b1;
          s_nxt.st = SLX_RET_NOP;
          s_nxt.nop_cyc = 1'b0;
        end else if (dec_call) begin
          // Push return address and jump; no other register touched
          s_nxt.push = 1'b1;
          s_nxt.push_data = pc_i + PC_STEP;
          s_nxt.pc_load = 1'b1;
          s_nxt.pc_wdata = {prog_counter_latch_upper_i[4:0],
            prog_counter_latch_high_i, working_register_i};
          s_nxt.flush = 1'b1;
          s_nxt.busy = 1'b1;
          s_nxt.st = SLX_CALL_NOP;
          s_nxt.nop_cyc = 1'b0;
        end
      end
      SLX_RET_NOP, SLX_CALL_NOP: begin
        // First Q4 closes the executing cycle, the second closes the nop
        // cycle; words offered meanwhile are refused
        if (phase_i == SLX_Q4) begin
          if (s_r.nop_cyc) begin
            s_nxt.st = SLX_IDLE;
            s_nxt.busy = 1'b0;
            s_nxt.nop_cyc = 1'b0;
          end else begin
            s_nxt.nop_cyc = 1'b1;
          end
        end
      end
      default: s_nxt.st = SLX_IDLE;
    endcase
  end

  // Register the state
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_r <= '{st: SLX_IDLE, ptr_wdata: 16'h0000, pc_wdata: 21'h00_0000,
        push_data: 21'h00_0000, default: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs come straight from the state register
  assign ptr_we_o = s_r.ptr_we;
  assign ptr_wdata_o = s_r.ptr_wdata;
  assign pc_load_o = s_r.pc_load;
  assign pc_wdata_o = s_r.pc_wdata;
  assign push_o = s_r.push;
  assign push_data_o = s_r.push_data;
  assign flush_o = s_r.flush;
  assign busy_o = s_r.busy;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  // Return form: pointer sum, stack top load and the nop tail
  a_ret_ptr_sum: assert property (
    @(posedge clk_i) disable iff (srst_i)
    dec_ret |=> ptr_we_o && ptr_wdata_o ==
      $past(stack_index_pointer_i) + {10'h000, $past(instr_i[5:0])})
    else $error("Pointer sum wrong after return-form add");

  a_ret_pc_top: assert property (
    @(posedge clk_i) disable iff (srst_i)
    dec_ret |=> pc_load_o && pc_wdata_o == $past(return_stack_top_i))
    else $error("Return did not load stack top");

  a_ret_two_cyc: assert property (
    @(posedge clk_i) disable iff (srst_i)
    dec_ret |=> busy_o ##1 (!ptr_we_o && !pc_load_o) [*3])
    else $error("Return second cycle not a nop");

  a_busy_span: assert property (
    @(posedge clk_i) disable iff (srst_i)
    $rose(busy_o) |-> busy_o [*7])
    else $error("Busy shorter than the rest of two cycles");

  a_busy_ends: assert property (
    @(posedge clk_i) disable iff (srst_i)
    busy_o && s_r.nop_cyc && phase_i == SLX_Q4 |=> !busy_o)
    else $error("Busy outlasts the nop cycle");

  // Decode qualifiers
  a_ret_decode: assert property (
    @(posedge clk_i) disable iff (srst_i)
    dec_ret |-> instr_i[15:6] == 10'h3A3)
    else $error("Return decoded from wrong word");

  a_ret_no_push: assert property (
    @(posedge clk_i) disable iff (srst_i)
    dec_ret |=> !push_o)
    else $error("Return form pushed onto the stack");

  a_sel_other: assert property (
    @(posedge clk_i) disable iff (srst_i)
    at_q1 && instr_i[15:8] == 8'hE8 && instr_i[7:6] != 2'h3
      |=> !pc_load_o && !ptr_we_o)
    else $error("Other pointer select taken as return form");

  a_no_ext_off: assert property (
    @(posedge clk_i) disable iff (srst_i)
    !ext_set_en_i |=> !pc_load_o && !push_o && !ptr_we_o)
    else $error("Extended op executed while disabled");

  // Computed call: push, target and flush
  a_call_only: assert property (
    @(posedge clk_i) disable iff (srst_i)
    push_o |-> $past(instr_i) == 16'h0014)
    else $error("Push from wrong word");

  a_call_push: assert property (
    @(posedge clk_i) disable iff (srst_i)
    dec_call |=> push_o && push_data_o == $past(pc_i) + 21'h00_0002
      && !ptr_we_o)
    else $error("Call return address wrong");

  a_call_target: assert property (
    @(posedge clk_i) disable iff (srst_i)
    dec_call |=> pc_wdata_o[7:0] == $past(working_register_i)
      && pc_wdata_o[15:8] == $past(prog_counter_latch_high_i)
      && pc_wdata_o[20:16] == $past(prog_counter_latch_upper_i[4:0]))
    else $error("Call target wrong");

  a_flush_redir: assert property (
    @(posedge clk_i) disable iff (srst_i)
    pc_load_o |-> flush_o && busy_o)
    else $error("Redirect without flush");

endmodule

// ===== slx_instr_exec_tb.sv
/*
  Self-checking bench for the stack-link instruction executor.
  Assumes the core phase sequence Q1..Q4 is modelled here, one phase
  a clock, and that the bench stands in for the register file.
*/
`timescale 1ns/1ps
module slx_instr_exec_tb;
  import slx_pkg::*;
  `define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
    $display("BAD %s exp %h got %h", n, e, g); mismatches++; end end
  logic clk_i = 0, srst_i = 1, ext_set_en_i = 1, instr_valid_i = 0;
  logic [1:0] phase_i = 2'h0;
  logic [15:0] instr_i = 16'h0000, stack_index_pointer_i = 16'h03FF;
  logic [20:0] pc_i = 21'h0F_FFFE, return_stack_top_i = 21'h0A_5432;
  logic [7:0] working_register_i = 8'h5A;
  logic [7:0] prog_counter_latch_high_i = 8'hC3;
  logic [7:0] prog_counter_latch_upper_i = 8'hF7;
  logic ptr_we_o, pc_load_o, push_o, flush_o, busy_o;
  logic [15:0] ptr_wdata_o;
  logic [20:0] pc_wdata_o, push_data_o;
  int mismatches = 0, cmp_count = 0;
  slx_instr_exec u_slx_instr_exec (.*);
  ////////////////////////////////////////////////////////////////////////
  // Clock and phase sequence, one phase a clock
  always #10 clk_i = ~clk_i;
  always @(negedge clk_i) phase_i <= phase_i + 2'h1;
  task automatic stop_test;
    if (mismatches == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Present a word at Q1 and check the common strobes one cycle later
  task automatic issue(input logic [15:0] w, input logic hit);
    for (int i = 0; i < 4 && phase_i !== 2'h3; i++) @(negedge clk_i);
    instr_i = w;
    instr_valid_i = 1'b1;
    @(negedge clk_i);
    instr_valid_i = 1'b0;
    `CHK("pc_load", hit, pc_load_o)
    `CHK("flush", hit, flush_o)
    `CHK("busy", hit, busy_o)
  endtask
  // Pulses last one cycle; busy covers the rest of both instruction
  // cycles, counted here from the clock after the pulse
  task automatic settle(input int exp_busy);
    int n;
    n = 0;
    @(negedge clk_i);
    `CHK("pulse", 1'b0, pc_load_o | ptr_we_o | push_o)
    while (n < 12 && busy_o === 1'b1) begin
      n++;
      @(negedge clk_i);
    end
    `CHK("busy_len", exp_busy, n)
    if (busy_o !== 1'b0) begin
      mismatches++;
      stop_test();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Return form at the literal's edges and one mid-range value
  task automatic t_return;
    logic [5:0] ks [3] = '{6'h00, 6'h23, 6'h3F};
    foreach (ks[i]) begin
      issue({8'hE8, 2'b11, ks[i]}, 1'b1);
      `CHK("ptr_we", 1'b1, ptr_we_o)
      `CHK("ptr", 16'h03FF + ks[i], ptr_wdata_o)
      `CHK("ret_pc", return_stack_top_i, pc_wdata_o)
      `CHK("no_push", 1'b0, push_o)
      settle(6);
    end
  endtask
  // Computed call: push next address, jump via latches and working reg
  task automatic t_call;
    issue(16'h0014, 1'b1);
    `CHK("push", 1'b1, push_o)
    `CHK("push_data", 21'h10_0000, push_data_o)
    `CHK("target", 21'h17_C35A, pc_wdata_o)
    `CHK("no_ptr", 1'b0, ptr_we_o)
    settle(6);
  endtask
  // A word offered at Q1 of the nop cycle must be ignored
  task automatic t_second;
    issue({8'hE8, 2'b11, 6'h01}, 1'b1);
    for (int i = 0; i < 4 && phase_i !== 2'h3; i++) @(negedge clk_i);
    instr_i = 16'h0014;
    instr_valid_i = 1'b1;
    @(negedge clk_i);
    instr_valid_i = 1'b0;
    `CHK("nop_cyc", 1'b0, pc_load_o | push_o | ptr_we_o)
    `CHK("nop_busy", 1'b1, busy_o)
    settle(2);
  endtask
  // Words that must be ignored: disabled set, one other select, two near misses
  task automatic t_refuse;
    logic [15:0] ws [5] = '{16'hE8FF, 16'h0014, 16'hE8BF, 16'h0015,
      16'h0004};
    foreach (ws[i]) begin
      ext_set_en_i = (i > 1);
      issue(ws[i], 1'b0);
      `CHK("ign_ptr", 1'b0, ptr_we_o | push_o)
      settle(0);
    end
    ext_set_en_i = 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(negedge clk_i);
    srst_i = 1'b0;
    t_return();
    t_call();
    t_second();
    t_refuse();
    t_return();
    stop_test();
  end
endmodule

// ===== slx_pkg.sv
/*
  Package for the stack-link instruction executor: opcode patterns,
  field positions, phase encoding and sequencer states.
  Assumes a core with a four-phase instruction cycle and 21-bit PC.
*/
package slx_pkg;

  // Instruction word and field layout
  localparam int INSTR_W = 16;
  localparam int PC_W = 21;
  localparam int LIT_LSB = 0;
  localparam int LIT_W = 6;
  localparam int SEL_LSB = 6;
  localparam int OPC_HI_LSB = 8;

  // Literal-add-to-pointer upper byte and pointer select for return form
  localparam logic [7:0] ADD_IDX_OPC = 8'hE8;
  localparam logic [1:0] SEL_STACK_RET = 2'h3;

  // Computed call full word
  localparam logic [15:0] CALL_WORK_WORD = 16'h0014;

  // Address step to the following instruction
  localparam logic [20:0] PC_STEP = 21'h00_0002;

  // Phases of one instruction cycle
  typedef enum logic [1:0] {
    SLX_Q1 = 2'b00,
    SLX_Q2 = 2'b01,
    SLX_Q3 = 2'b10,
    SLX_Q4 = 2'b11
  } slx_phase_e;

  // Execute sequencer states
  typedef enum logic [1:0] {
    SLX_IDLE = 2'b00,
    SLX_RET_NOP = 2'b01,
    SLX_CALL_NOP = 2'b10
  } slx_state_e;

endpackage
